// [tmr_pkg.sv]
package tmr_pkg;

	// ==========================================================
	// Register offsets on the plain register port.
	// ==========================================================
	localparam logic [3:0] OFF_PRESCALER_CONTROL = 4'h0;  // Prescaler run bit.
	localparam logic [3:0] OFF_PRESCALER_RELOAD  = 4'h1;  // Write loads prescaler and reload.
	localparam logic [3:0] OFF_TIMER1_CONTROL    = 4'h2;  // Timer 1 control.
	localparam logic [3:0] OFF_TIMER2_CONTROL    = 4'h3;  // Timer 2 control.
	localparam logic [3:0] OFF_PIN0_CONFIG       = 4'h4;  // Counter pin 0 configuration.
	localparam logic [3:0] OFF_PIN1_CONFIG       = 4'h5;  // Counter pin 1 configuration.
	localparam logic [3:0] OFF_INTERRUPT_CONTROL = 4'h6;  // Interrupt control.
	localparam logic [3:0] OFF_TIMER1_COUNT      = 4'h7;  // Write loads counter and low reload.
	localparam logic [3:0] OFF_TIMER1_HIGH       = 4'h8;  // Timer 1 high reload.
	localparam logic [3:0] OFF_TIMER1_COPY       = 4'h9;  // Write copies low reload to counter.
	localparam logic [3:0] OFF_TIMER2_COUNT      = 4'ha;  // Write loads counter and low reload.
	localparam logic [3:0] OFF_TIMER2_HIGH       = 4'hb;  // Timer 2 high reload.
	localparam logic [3:0] OFF_TIMER2_COPY       = 4'hc;  // Write copies low reload to counter.
	localparam logic [3:0] OFF_FLAGS             = 4'hd;  // Request flags, write 1 to clear.

	// ==========================================================
	// Field positions.
	// ==========================================================
	localparam int BIT_RUN      = 0;  // Prescaler run bit.
	localparam int BIT_T_RUN    = 2;  // Timer run bit.
	localparam int BIT_T_PWM    = 3;  // Timer PWM enable bit.
	localparam int BIT_P_EDGE   = 0;  // Pin edge select, 1 rising.
	localparam int BIT_P_SYNC   = 1;  // Start sync or period count.
	localparam int BIT_P_AUTO   = 2;  // Auto stop or output gating.
	localparam int BIT_P_OUT    = 3;  // Pin output enable.
	localparam int BIT_I_T1PIN  = 0;  // Pin control of timer 1.
	localparam int BIT_I_EDGE   = 2;  // Interrupt pin edge, 1 rising.
	localparam int BIT_I_PINEN  = 3;  // Interrupt pin input enable.

	// ==========================================================
	// Reset values and source codes.
	// ==========================================================
	localparam logic [3:0] RST_CTRL  = 4'h0;   // Control reset value.
	localparam logic [7:0] RST_COUNT = 8'hff;  // Counter and reload reset value.
	localparam logic [1:0] SRC_A     = 2'h0;   // Chained source.
	localparam logic [1:0] SRC_PRE   = 2'h1;   // Prescaler output.
	localparam logic [1:0] SRC_PIN   = 2'h2;   // Counter pin input.
	localparam logic [1:0] SRC_CLK   = 2'h3;   // Free clock.

endpackage

// [tmr_top.sv]
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
// Operation
// - Prescaler divides instruction clock by n+1.
// - Prescaler counts only while run bit set.
// - Prescaler reloads at underflow, feeds both timers.
// - Timer 1 load, high load, copy, read.
// - Timer 1 counts only while run bit set.
// - Timer 1 divides by n+1 or m+1.
// - Timer 1 underflow sets flag, reloads low.
// - Timer 1 PWM alternates low and high reloads.
// - First PWM drives pin 0 when enabled.
// - Timer 1 control write waits out high.
// - Interrupt pin edge sets start sync latch.
// - Start latch cleared by control, reset, autostop.
// - Auto stop halts timer 1 at underflow.
// - Timer 2 offers same counter operations.
// - Timer 2 counts only while run bit set.
// - Timer 2 underflow sets flag, reloads low.
// - Timer 2 PWM alternates low and high reloads.
// - Second PWM drives pin 1 when enabled.
// - Timer 1 underflow toggles pin 1 gating.
// - Interrupt pin edges toggle timer 2 gate.
// - Pin edges feed the other timer.
// - Timer 1 source field encoding.
// - Timer 2 source field encoding.
// - Edge bit zero falling, one rising.
// - Request flags clear on service.

module tmr_top (
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr_stb,
	input  wire logic       rd_stb,
	output logic      [7:0] rdata,
	input  wire logic       instruction_clock,
	input  wire logic       osc_clock,
	input  wire logic       int_pin,
	input  wire logic       counter_pin_0_in,
	input  wire logic       counter_pin_1_in,
	output logic            counter_pin_0_out,
	output logic            counter_pin_0_oe,
	output logic            counter_pin_1_out,
	output logic            counter_pin_1_oe,
	output logic            timer1_request_flag,
	output logic            timer2_request_flag
);

	// ==========================================================
	// State record.
	// ==========================================================
	typedef struct packed {
		logic       pre_run;      // Prescaler run bit.
		logic [7:0] pre_cnt;      // Prescaler count.
		logic [7:0] pre_rld;      // Prescaler reload.
		logic       pre_out;      // Prescaler output pulse.
		logic [3:0] t1_ctl;       // Timer 1 control.
		logic [3:0] t1_pend;      // Deferred timer 1 control.
		logic       t1_pv;        // Deferred write pending.
		logic [3:0] t2_ctl;       // Timer 2 control.
		logic [3:0] t2_pend;      // Deferred timer 2 control.
		logic       t2_pv;        // Deferred write pending.
		logic [3:0] p0_cfg;       // Pin 0 configuration.
		logic [3:0] p1_cfg;       // Pin 1 configuration.
		logic [3:0] int_ctl;      // Interrupt control.
		logic [7:0] t1_cnt;       // Timer 1 count.
		logic [7:0] t1_lo;        // Timer 1 low reload.
		logic [7:0] t1_hi;        // Timer 1 high reload.
		logic       t1_pwm;       // First PWM waveform.
		logic [7:0] t2_cnt;       // Timer 2 count.
		logic [7:0] t2_lo;        // Timer 2 low reload.
		logic [7:0] t2_hi;        // Timer 2 high reload.
		logic       t2_pwm;       // Second PWM waveform.
		logic       t2_rise;      // Second PWM rising pulse.
		logic       t1_udf;       // Timer 1 underflow pulse.
		logic       sync_latch;   // Start synchronisation latch.
		logic       per_gate;     // Period count gate.
		logic       out_gate;     // Pin 1 output gating.
		logic [2:0] s_inst;       // Instruction clock synchroniser.
		logic [2:0] s_osc;        // Oscillator synchroniser.
		logic [2:0] s_int;        // Interrupt pin synchroniser.
		logic [2:0] s_p0;         // Pin 0 synchroniser.
		logic [2:0] s_p1;         // Pin 1 synchroniser.
		logic       l_inst;       // Agreed instruction clock level.
		logic       l_osc;        // Agreed oscillator level.
		logic       l_int;        // Agreed interrupt pin level.
		logic       l_p0;         // Agreed pin 0 level.
		logic       l_p1;         // Agreed pin 1 level.
		logic       f1;           // Timer 1 request flag.
		logic       f2;           // Timer 2 request flag.
		logic [7:0] rd;           // Read data.
		logic       p0o;          // Pin 0 output.
		logic       p0e;          // Pin 0 enable.
		logic       p1o;          // Pin 1 output.
		logic       p1e;          // Pin 1 enable.
	} state_s;

	state_s st_q;  // Registered state.
	state_s st_d;  // Next state.

	// ==========================================================
	// Next state logic.
	// ==========================================================
	// Counting advances on one-cycle enables from the edges, except timer 2 source 3, which counts every cycle.
	always_comb begin
		logic inst_rise;   // Instruction clock rising edge.
		logic osc_rise;    // Oscillator rising edge.
		logic int_edge;    // Valid interrupt pin edge.
		logic p0_edge;     // Counted pin 0 edge.
		logic p1_edge;     // Counted pin 1 edge.
		logic pre_tick;    // Prescaler count pulse.
		logic src1;        // Timer 1 selected source pulse.
		logic src2;        // Timer 2 selected source pulse.
		logic cnt1;        // Timer 1 count enable.
		logic cnt2;        // Timer 2 count enable.
		logic udf1;        // Timer 1 underflow now.
		logic udf2;        // Timer 2 underflow now.
		inst_rise = 1'b0;
		osc_rise  = 1'b0;
		int_edge  = 1'b0;
		p0_edge   = 1'b0;
		p1_edge   = 1'b0;
		pre_tick  = 1'b0;
		src1      = 1'b0;
		src2      = 1'b0;
		cnt1      = 1'b0;
		cnt2      = 1'b0;
		udf1      = 1'b0;
		udf2      = 1'b0;
		st_d      = st_q;

		// Three-stage synchronisers; a level counts once stages two and three agree.
		st_d.s_inst = {st_q.s_inst[1:0], instruction_clock};
		st_d.s_osc  = {st_q.s_osc[1:0], osc_clock};
		st_d.s_int  = {st_q.s_int[1:0], int_pin};
		st_d.s_p0   = {st_q.s_p0[1:0], counter_pin_0_in};
		st_d.s_p1   = {st_q.s_p1[1:0], counter_pin_1_in};
		if (st_q.s_inst[1] == st_q.s_inst[2]) begin
			st_d.l_inst = st_q.s_inst[2];
		end
		if (st_q.s_osc[1] == st_q.s_osc[2]) begin
			st_d.l_osc = st_q.s_osc[2];
		end
		if (st_q.s_int[1] == st_q.s_int[2]) begin
			st_d.l_int = st_q.s_int[2];
		end
		if (st_q.s_p0[1] == st_q.s_p0[2]) begin
			st_d.l_p0 = st_q.s_p0[2];
		end
		if (st_q.s_p1[1] == st_q.s_p1[2]) begin
			st_d.l_p1 = st_q.s_p1[2];
		end
		inst_rise = st_d.l_inst & ~st_q.l_inst;
		osc_rise  = st_d.l_osc & ~st_q.l_osc;
		int_edge  = st_q.int_ctl[tmr_pkg::BIT_I_PINEN] &
			(st_d.l_int != st_q.l_int) &
			(st_d.l_int == st_q.int_ctl[tmr_pkg::BIT_I_EDGE]);
		p0_edge = (st_d.l_p0 != st_q.l_p0) &
			(st_d.l_p0 == st_q.p0_cfg[tmr_pkg::BIT_P_EDGE]);
		p1_edge = (st_d.l_p1 != st_q.l_p1) &
			(st_d.l_p1 == st_q.p1_cfg[tmr_pkg::BIT_P_EDGE]);

		pre_tick = st_q.pre_run & inst_rise;
		st_d.pre_out = 1'b0;
		if (pre_tick) begin
			if (st_q.pre_cnt == 8'h00) begin
				st_d.pre_cnt = st_q.pre_rld;
				st_d.pre_out = 1'b1;
			end else begin
				st_d.pre_cnt = st_q.pre_cnt - 8'h01;
			end
		end

		case (st_q.t1_ctl[1:0])
			tmr_pkg::SRC_A:   src1 = st_q.t2_rise;
			tmr_pkg::SRC_PRE: src1 = st_q.pre_out;
			tmr_pkg::SRC_PIN: src1 = p1_edge;
			default:          src1 = osc_rise;
		endcase
		case (st_q.t2_ctl[1:0])
			tmr_pkg::SRC_A:   src2 = st_q.t1_udf;
			tmr_pkg::SRC_PRE: src2 = st_q.pre_out;
			tmr_pkg::SRC_PIN: src2 = p0_edge;
			default:          src2 = 1'b1;
		endcase

		if (st_q.int_ctl[tmr_pkg::BIT_I_T1PIN] & st_q.p0_cfg[tmr_pkg::BIT_P_SYNC]) begin
			cnt1 = src1 & st_q.t1_ctl[tmr_pkg::BIT_T_RUN] & st_q.sync_latch;
		end else begin
			cnt1 = src1 & st_q.t1_ctl[tmr_pkg::BIT_T_RUN];
		end
		if (st_q.p1_cfg[tmr_pkg::BIT_P_SYNC]) begin
			cnt2 = src2 & st_q.t2_ctl[tmr_pkg::BIT_T_RUN] & st_q.per_gate;
		end else begin
			cnt2 = src2 & st_q.t2_ctl[tmr_pkg::BIT_T_RUN];
		end

		udf1 = cnt1 & (st_q.t1_cnt == 8'h00);
		st_d.t1_udf = udf1;
		if (cnt1) begin
			if (udf1) begin
				if (st_q.t1_ctl[tmr_pkg::BIT_T_PWM] & ~st_q.t1_pwm) begin
					st_d.t1_cnt = st_q.t1_hi;
					st_d.t1_pwm = 1'b1;
				end else begin
					st_d.t1_cnt = st_q.t1_lo;
					st_d.t1_pwm = 1'b0;
				end
			end else begin
				st_d.t1_cnt = st_q.t1_cnt - 8'h01;
			end
		end
		udf2 = cnt2 & (st_q.t2_cnt == 8'h00);
		if (cnt2) begin
			if (udf2) begin
				if (st_q.t2_ctl[tmr_pkg::BIT_T_PWM] & ~st_q.t2_pwm) begin
					st_d.t2_cnt = st_q.t2_hi;
					st_d.t2_pwm = 1'b1;
				end else begin
					st_d.t2_cnt = st_q.t2_lo;
					st_d.t2_pwm = 1'b0;
				end
			end else begin
				st_d.t2_cnt = st_q.t2_cnt - 8'h01;
			end
		end

		// Pulse on each rise of the second PWM, a timer 1 source.
		st_d.t2_rise = st_d.t2_pwm & ~st_q.t2_pwm;

		if (st_q.t1_pv & ~st_d.t1_pwm) begin
			st_d.t1_ctl = st_q.t1_pend;
			st_d.t1_pv  = 1'b0;
		end
		if (st_q.t2_pv & ~st_d.t2_pwm) begin
			st_d.t2_ctl = st_q.t2_pend;
			st_d.t2_pv  = 1'b0;
		end

		if (~st_q.int_ctl[tmr_pkg::BIT_I_T1PIN]) begin
			st_d.sync_latch = 1'b0;
		end else if (udf1 & st_q.p0_cfg[tmr_pkg::BIT_P_AUTO] &
				st_q.p0_cfg[tmr_pkg::BIT_P_SYNC]) begin
			st_d.sync_latch = 1'b0;
		end else if (int_edge & st_q.p0_cfg[tmr_pkg::BIT_P_SYNC]) begin
			st_d.sync_latch = 1'b1;
		end
		if (~st_q.int_ctl[tmr_pkg::BIT_I_PINEN]) begin
			st_d.per_gate = 1'b0;
		end else if (int_edge) begin
			st_d.per_gate = ~st_q.per_gate;
		end
		if (~st_q.t1_ctl[tmr_pkg::BIT_T_RUN]) begin
			st_d.out_gate = 1'b0;
		end else if (udf1) begin
			st_d.out_gate = ~st_q.out_gate;
		end

		if (wr_stb && addr == tmr_pkg::OFF_FLAGS) begin
			st_d.f1 = st_q.f1 & ~wdata[0];
			st_d.f2 = st_q.f2 & ~wdata[1];
		end
		if (udf1) begin
			st_d.f1 = 1'b1;
		end
		if (udf2) begin
			st_d.f2 = 1'b1;
		end

		if (wr_stb) begin
			if (addr == tmr_pkg::OFF_PRESCALER_CONTROL) begin
				st_d.pre_run = wdata[tmr_pkg::BIT_RUN];
				if (~wdata[tmr_pkg::BIT_RUN]) begin
					st_d.pre_cnt = st_q.pre_rld;
				end
			end else if (addr == tmr_pkg::OFF_PRESCALER_RELOAD) begin
				st_d.pre_cnt = wdata;
				st_d.pre_rld = wdata;
			end else if (addr == tmr_pkg::OFF_TIMER1_CONTROL) begin
				if (st_d.t1_pwm) begin
					st_d.t1_pend = wdata[3:0];
					st_d.t1_pv   = 1'b1;
				end else begin
					st_d.t1_ctl = wdata[3:0];
				end
			end else if (addr == tmr_pkg::OFF_TIMER2_CONTROL) begin
				if (st_d.t2_pwm) begin
					st_d.t2_pend = wdata[3:0];
					st_d.t2_pv   = 1'b1;
				end else begin
					st_d.t2_ctl = wdata[3:0];
				end
			end else if (addr == tmr_pkg::OFF_PIN0_CONFIG) begin
				st_d.p0_cfg = wdata[3:0];
			end else if (addr == tmr_pkg::OFF_PIN1_CONFIG) begin
				st_d.p1_cfg = wdata[3:0];
			end else if (addr == tmr_pkg::OFF_INTERRUPT_CONTROL) begin
				st_d.int_ctl = wdata[3:0];
			end else if (addr == tmr_pkg::OFF_TIMER1_COUNT) begin
				st_d.t1_cnt = wdata;
				st_d.t1_lo  = wdata;
			end else if (addr == tmr_pkg::OFF_TIMER1_HIGH) begin
				st_d.t1_hi = wdata;
			end else if (addr == tmr_pkg::OFF_TIMER1_COPY) begin
				st_d.t1_cnt = st_q.t1_lo;
			end else if (addr == tmr_pkg::OFF_TIMER2_COUNT) begin
				st_d.t2_cnt = wdata;
				st_d.t2_lo  = wdata;
			end else if (addr == tmr_pkg::OFF_TIMER2_HIGH) begin
				st_d.t2_hi = wdata;
			end else if (addr == tmr_pkg::OFF_TIMER2_COPY) begin
				st_d.t2_cnt = st_q.t2_lo;
			end
		end

		// Read data holds only in the cycle after the strobe.
		st_d.rd = 8'h00;
		if (rd_stb) begin
			if (addr == tmr_pkg::OFF_PRESCALER_CONTROL) begin
				st_d.rd = {7'h00, st_q.pre_run};
			end else if (addr == tmr_pkg::OFF_PRESCALER_RELOAD) begin
				st_d.rd = st_q.pre_rld;
			end else if (addr == tmr_pkg::OFF_TIMER1_CONTROL) begin
				st_d.rd = {4'h0, st_q.t1_ctl};
			end else if (addr == tmr_pkg::OFF_TIMER2_CONTROL) begin
				st_d.rd = {4'h0, st_q.t2_ctl};
			end else if (addr == tmr_pkg::OFF_PIN0_CONFIG) begin
				st_d.rd = {4'h0, st_q.p0_cfg};
			end else if (addr == tmr_pkg::OFF_PIN1_CONFIG) begin
				st_d.rd = {4'h0, st_q.p1_cfg};
			end else if (addr == tmr_pkg::OFF_INTERRUPT_CONTROL) begin
				st_d.rd = {4'h0, st_q.int_ctl};
			end else if (addr == tmr_pkg::OFF_TIMER1_COUNT) begin
				st_d.rd = st_q.t1_cnt;
			end else if (addr == tmr_pkg::OFF_TIMER2_COUNT) begin
				st_d.rd = st_q.t2_cnt;
			end else if (addr == tmr_pkg::OFF_FLAGS) begin
				st_d.rd = {6'h00, st_q.f2, st_q.f1};
			end
		end

		st_d.p0e = st_q.p0_cfg[tmr_pkg::BIT_P_OUT];
		st_d.p0o = st_q.p0_cfg[tmr_pkg::BIT_P_OUT] & st_q.t1_pwm;
		st_d.p1e = st_q.p1_cfg[tmr_pkg::BIT_P_OUT];
		st_d.p1o = st_q.p1_cfg[tmr_pkg::BIT_P_OUT] & st_q.t2_pwm &
			(~st_q.p1_cfg[tmr_pkg::BIT_P_AUTO] | st_q.out_gate);
	end

	// ==========================================================
	// State register.
	// ==========================================================
	// Every field resets to a constant.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_q         <= '0;
			st_q.pre_cnt <= tmr_pkg::RST_COUNT;
			st_q.pre_rld <= tmr_pkg::RST_COUNT;
			st_q.t1_cnt  <= tmr_pkg::RST_COUNT;
			st_q.t1_lo   <= tmr_pkg::RST_COUNT;
			st_q.t1_hi   <= tmr_pkg::RST_COUNT;
			st_q.t2_cnt  <= tmr_pkg::RST_COUNT;
			st_q.t2_lo   <= tmr_pkg::RST_COUNT;
			st_q.t2_hi   <= tmr_pkg::RST_COUNT;
			st_q.t1_ctl  <= tmr_pkg::RST_CTRL;
			st_q.t2_ctl  <= tmr_pkg::RST_CTRL;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs come straight from state flip-flops.
	assign rdata               = st_q.rd;
	assign counter_pin_0_out   = st_q.p0o;
	assign counter_pin_0_oe    = st_q.p0e;
	assign counter_pin_1_out   = st_q.p1o;
	assign counter_pin_1_oe    = st_q.p1e;
	assign timer1_request_flag = st_q.f1;
	assign timer2_request_flag = st_q.f2;

	// ==========================================================
	// Assertions.
	// ==========================================================
	sequence t1_zero_tick;
		st_q.t1_cnt == 8'h00 && st_q.t1_udf == 1'b0;
	endsequence

	AST_FLAG1_ON_UDF: assert property (@(posedge ref_clk) disable iff (!nrst)
		st_q.t1_udf |-> st_q.f1) else $error("timer 1 underflow without flag");
	AST_FLAG2_HOLDS: assert property (@(posedge ref_clk) disable iff (!nrst)
		st_q.f2 && !(wr_stb && addr == tmr_pkg::OFF_FLAGS) |=> st_q.f2)
		else $error("timer 2 flag lost");
	AST_PRE_STOP: assert property (@(posedge ref_clk) disable iff (!nrst)
		!st_q.pre_run && !wr_stb |=> !st_q.pre_out) else $error("prescaler ran stopped");
	AST_T1_HOLD: assert property (@(posedge ref_clk) disable iff (!nrst)
		!st_q.t1_ctl[tmr_pkg::BIT_T_RUN] && !wr_stb |=> $stable(st_q.t1_cnt))
		else $error("timer 1 moved while stopped");
	AST_T2_HOLD: assert property (@(posedge ref_clk) disable iff (!nrst)
		!st_q.t2_ctl[tmr_pkg::BIT_T_RUN] && !wr_stb |=> $stable(st_q.t2_cnt))
		else $error("timer 2 moved while stopped");
	AST_PIN0_QUIET: assert property (@(posedge ref_clk) disable iff (!nrst)
		!st_q.p0_cfg[tmr_pkg::BIT_P_OUT] |=> !st_q.p0e) else $error("pin 0 driven");
	AST_PIN1_QUIET: assert property (@(posedge ref_clk) disable iff (!nrst)
		!st_q.p1_cfg[tmr_pkg::BIT_P_OUT] |=> !st_q.p1o) else $error("pin 1 driven");
	AST_GATE_CANCEL: assert property (@(posedge ref_clk) disable iff (!nrst)
		!st_q.t1_ctl[tmr_pkg::BIT_T_RUN] |=> !st_q.out_gate) else $error("gating kept");
	AST_LATCH_CLEAR: assert property (@(posedge ref_clk) disable iff (!nrst)
		!st_q.int_ctl[tmr_pkg::BIT_I_T1PIN] |=> !st_q.sync_latch) else $error("latch kept");
	AST_PER_CLEAR: assert property (@(posedge ref_clk) disable iff (!nrst)
		!st_q.int_ctl[tmr_pkg::BIT_I_PINEN] |=> !st_q.per_gate) else $error("gate kept");
	AST_T1_RELOAD: assert property (@(posedge ref_clk) disable iff (!nrst)
		st_q.t1_udf && st_q.t1_pwm |-> st_q.t1_cnt == st_q.t1_hi)
		else $error("timer 1 high reload wrong");
	AST_ZERO_SEQ: assert property (@(posedge ref_clk) disable iff (!nrst)
		t1_zero_tick ##0 !st_q.t1_ctl[tmr_pkg::BIT_T_RUN] && !wr_stb |=> !st_q.t1_udf)
		else $error("timer 1 underflow while stopped");

endmodule // tmr_top

// [tmr_far_side.sv]
`timescale 1ns/1ps
// ==========================================================
// Far side: clock sources, interrupt pin and counter pin wires.
// ==========================================================
module tmr_far_side (
	input  wire logic ref_clk,
	input  wire logic pin0_oe,
	input  wire logic pin0_out,
	input  wire logic pin1_oe,
	input  wire logic pin1_out,
	output logic      instruction_clock,
	output logic      osc_clock,
	output logic      int_pin,
	output logic      pin0_level,
	output logic      pin1_level
);
	logic [3:0] div_q = 4'h0;  // Free divider for both clock sources.
	logic       drv0  = 1'b0;  // Level that the outside drives onto pin 0.
	logic       drv_int = 1'b0;  // Level that the outside drives onto the interrupt pin.
	// Both sources run free; the instruction clock has a period of four cycles.
	always_ff @(posedge ref_clk) begin
		div_q <= div_q + 4'h1;
	end
	assign instruction_clock = div_q[1];
	assign osc_clock         = div_q[2];
	assign int_pin           = drv_int;
	// Each wire shows the design's level while the design drives it.
	assign pin0_level = pin0_oe ? pin0_out : drv0;
	assign pin1_level = pin1_oe ? pin1_out : 1'b0;
	task automatic pulses(input int k, input bit on_int);
		for (int i = 0; i < k; i++) begin
			repeat (4) @(posedge ref_clk);
			if (on_int) begin
				drv_int <= 1'b1;
			end else begin
				drv0 <= 1'b1;
			end
			repeat (4) @(posedge ref_clk);
			drv_int <= 1'b0;
			drv0    <= 1'b0;
		end
	endtask
endmodule // tmr_far_side

// [testbench.sv]
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the prescaler and the two timers.
// ==========================================================
module testbench;
	logic       ref_clk = 1'b0;  // System clock.
	logic       nrst;            // Reset, active low.
	logic [3:0] addr;            // Register index.
	logic [7:0] wdata;           // Write data.
	logic       wr_stb;          // Write strobe.
	logic       rd_stb;          // Read strobe.
	logic [7:0] rdata;           // Read data.
	logic       ick, ock, ipin, p0_in, p1_in, p0_out, p0_oe, p1_out, p1_oe, f1, f2;
	logic [7:0] v, v2;           // Values read back.
	int         seed = 9133;     // Fixed random seed.
	int         bad_count = 0;   // Mismatches seen.
	int         comparisons = 0; // Comparisons made.
	int         cyc = 0;         // Cycle counter for interval timing.
	int         n, m, p, t0, t1, t2;
	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) cyc <= cyc + 1;
	tmr_top dut_u (.ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .instruction_clock(ick),
		.osc_clock(ock), .int_pin(ipin), .counter_pin_0_in(p0_in),
		.counter_pin_1_in(p1_in), .counter_pin_0_out(p0_out), .counter_pin_0_oe(p0_oe),
		.counter_pin_1_out(p1_out), .counter_pin_1_oe(p1_oe),
		.timer1_request_flag(f1), .timer2_request_flag(f2));
	tmr_far_side far_u (.ref_clk(ref_clk), .pin0_oe(p0_oe), .pin0_out(p0_out),
		.pin1_oe(p1_oe), .pin1_out(p1_out), .instruction_clock(ick), .osc_clock(ock),
		.int_pin(ipin), .pin0_level(p0_in), .pin1_level(p1_in));
	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Compares one value with its expectation.
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// One-cycle write strobe.
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge ref_clk);
		wr_stb <= 1'b0;
	endtask
	// One-cycle read strobe; data is taken in the following cycle only.
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge ref_clk);
		rd_stb <= 1'b0;
		@(negedge ref_clk);
		d = rdata;
	endtask
	// Bounded wait for a flag or a pin output to reach a level.
	task automatic wait_lvl(input int w, input logic lvl, output int t);
		logic s;
		for (int i = 0; i < 2000; i++) begin
			@(negedge ref_clk);
			s = (w == 0) ? f1 : (w == 1) ? f2 : (w == 2) ? p1_out : p0_out;
			if (s === lvl) begin
				t = cyc;
				return;
			end
		end
		bad_count++;
		$display("[FAIL] wait expected %0d seen timeout", lvl);
		stop_test();
	endtask
	// Clears the flags, then times the next rise of the chosen flag.
	task automatic rise(input int w, output int t);
		wr(tmr_pkg::OFF_FLAGS, 8'h03);
		wait_lvl(w, 1'b0, t);
		wait_lvl(w, 1'b1, t);
	endtask
	initial begin
		nrst = 1'b0;
		addr = 4'h0;
		wdata = 8'h00;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
		repeat (6) @(posedge ref_clk);
		nrst <= 1'b1;
		// Reset values, load and read back, unmapped read.
		rd(tmr_pkg::OFF_TIMER1_COUNT, v); chk("t1 reset", v, tmr_pkg::RST_COUNT);
		rd(tmr_pkg::OFF_FLAGS, v); chk("flags reset", v, 8'h00);
		rd(4'he, v); chk("unmapped", v, 8'h00);
		wr(tmr_pkg::OFF_TIMER1_COUNT, 8'h5a);
		rd(tmr_pkg::OFF_TIMER1_COUNT, v); chk("t1 load", v, 8'h5a);
		wr(tmr_pkg::OFF_TIMER2_COUNT, 8'hc3);
		rd(tmr_pkg::OFF_TIMER2_COUNT, v); chk("t2 load", v, 8'hc3);
		$display("test registers done");
		n = 4 + ($unsigned($random(seed)) % 16);
		wr(tmr_pkg::OFF_TIMER2_COUNT, 8'(n));
		wr(tmr_pkg::OFF_TIMER2_CONTROL, 8'h07);
		rise(1, t0);
		rise(1, t1);
		chk("t2 period", 8'(t1 - t0), 8'(n + 1));
		wr(tmr_pkg::OFF_TIMER2_CONTROL, 8'h03);
		rd(tmr_pkg::OFF_TIMER2_COUNT, v);
		repeat (8) @(posedge ref_clk);
		rd(tmr_pkg::OFF_TIMER2_COUNT, v2); chk("t2 hold", v2, v);
		wr(tmr_pkg::OFF_TIMER2_COPY, 8'h00);
		rd(tmr_pkg::OFF_TIMER2_COUNT, v); chk("t2 copy", v, 8'(n));
		$display("test timer2 system clock done");
		wr(tmr_pkg::OFF_PRESCALER_RELOAD, 8'h01);
		wr(tmr_pkg::OFF_PRESCALER_CONTROL, 8'h01);
		n = 4 + ($unsigned($random(seed)) % 4);
		wr(tmr_pkg::OFF_TIMER1_COUNT, 8'(n));
		wr(tmr_pkg::OFF_TIMER1_CONTROL, 8'h05);
		rise(0, t0);
		rise(0, t1);
		chk("t1 prescaled", 8'(t1 - t0), 8'(8 * (n + 1)));
		wr(tmr_pkg::OFF_TIMER1_CONTROL, 8'h01);
		wr(tmr_pkg::OFF_TIMER1_COPY, 8'h00);
		rd(tmr_pkg::OFF_TIMER1_COUNT, v); chk("t1 copy", v, 8'(n));
		rd(tmr_pkg::OFF_PRESCALER_RELOAD, v); chk("pre reload", v, 8'h01);
		$display("test timer1 prescaler done");
		n = 2 + ($unsigned($random(seed)) % 6);
		m = 2 + ($unsigned($random(seed)) % 6);
		wr(tmr_pkg::OFF_TIMER2_COUNT, 8'(n));
		wr(tmr_pkg::OFF_TIMER2_HIGH, 8'(m));
		wr(tmr_pkg::OFF_PIN1_CONFIG, 8'h08);
		wr(tmr_pkg::OFF_TIMER2_CONTROL, 8'h0f);
		wait_lvl(2, 1'b1, t0);
		wait_lvl(2, 1'b0, t1);
		wait_lvl(2, 1'b1, t2);
		chk("pwm high", 8'(t1 - t0), 8'(m + 1));
		chk("pwm low", 8'(t2 - t1), 8'(n + 1));
		chk("pin1 oe", {7'h00, p1_oe}, 8'h01);
		chk("pin0 oe", {7'h00, p0_oe}, 8'h00);
		wr(tmr_pkg::OFF_TIMER2_CONTROL, 8'h00);
		wr(tmr_pkg::OFF_PIN1_CONFIG, 8'h00);
		$display("test pwm done");
		for (int e = 0; e < 2; e++) begin
			wr(tmr_pkg::OFF_PIN0_CONFIG, 8'(e));
			wr(tmr_pkg::OFF_TIMER2_COUNT, 8'h20);
			wr(tmr_pkg::OFF_TIMER2_CONTROL, 8'h06);
			far_u.pulses(5, 1'b0);
			repeat (10) @(posedge ref_clk);
			wr(tmr_pkg::OFF_TIMER2_CONTROL, 8'h02);
			rd(tmr_pkg::OFF_TIMER2_COUNT, v); chk("pin0 count", v, 8'h1b);
		end
		$display("test pin edges done");
		// edges open and close timer 2
		wr(tmr_pkg::OFF_INTERRUPT_CONTROL, 8'h0c);
		wr(tmr_pkg::OFF_PIN1_CONFIG, 8'h02);
		wr(tmr_pkg::OFF_TIMER2_COUNT, 8'h80);
		wr(tmr_pkg::OFF_TIMER2_CONTROL, 8'h07);
		far_u.pulses(2, 1'b1);
		repeat (10) @(posedge ref_clk);
		wr(tmr_pkg::OFF_TIMER2_CONTROL, 8'h03);
		rd(tmr_pkg::OFF_TIMER2_COUNT, v); chk("period count", v, 8'h78);
		$display("test period count done");
		wr(tmr_pkg::OFF_TIMER1_COUNT, 8'h03);
		wr(tmr_pkg::OFF_PIN0_CONFIG, 8'h06);
		wr(tmr_pkg::OFF_INTERRUPT_CONTROL, 8'h0d);
		wr(tmr_pkg::OFF_TIMER1_CONTROL, 8'h07);
		wr(tmr_pkg::OFF_FLAGS, 8'h03);
		repeat (20) @(posedge ref_clk);
		rd(tmr_pkg::OFF_TIMER1_COUNT, v); chk("sync wait", v, 8'h03);
		far_u.pulses(1, 1'b1);
		repeat (60) @(posedge ref_clk);
		rd(tmr_pkg::OFF_FLAGS, v); chk("sync flag", v, 8'h01);
		rd(tmr_pkg::OFF_TIMER1_COUNT, v); chk("auto stop", v, 8'h03);
		wr(tmr_pkg::OFF_FLAGS, 8'h03);
		repeat (40) @(posedge ref_clk);
		rd(tmr_pkg::OFF_FLAGS, v); chk("stay stopped", v, 8'h00);
		wr(tmr_pkg::OFF_TIMER1_CONTROL, 8'h00);
		$display("test start sync done");
		n = 1 + ($unsigned($random(seed)) % 3);
		m = 1 + ($unsigned($random(seed)) % 3);
		wr(tmr_pkg::OFF_TIMER1_COUNT, 8'(n));
		wr(tmr_pkg::OFF_TIMER1_HIGH, 8'(m));
		wr(tmr_pkg::OFF_PIN0_CONFIG, 8'h08);
		wr(tmr_pkg::OFF_TIMER1_CONTROL, 8'h0d);
		wait_lvl(3, 1'b1, t0);
		wait_lvl(3, 1'b0, t1);
		wait_lvl(3, 1'b1, t2);
		chk("first_pwm_waveform high", 8'(t1 - t0), 8'(8 * (m + 1)));
		chk("first_pwm_waveform low", 8'(t2 - t1), 8'(8 * (n + 1)));
		chk("pin0 drive", {7'h00, p0_oe}, 8'h01);
		wr(tmr_pkg::OFF_TIMER1_CONTROL, 8'h00);
		rd(tmr_pkg::OFF_TIMER1_CONTROL, v); chk("ctl held", v, 8'h0d);
		wait_lvl(3, 1'b0, t0);
		rd(tmr_pkg::OFF_TIMER1_CONTROL, v); chk("ctl applied", v, 8'h00);
		$display("test first_pwm_waveform done");
		stop_test();
	end
endmodule // testbench
